// ---- hw/dpio_pkg.sv ----
// Purpose: Constants and carrier types for the dual parallel I/O ports
// Assumes: APB slave, 32-bit data, 8-bit ports in the low byte
// Notes:   Registers are numbered by index; the byte address is four times the index
//
// Functional notes
// - The first port is eight bits wide and its upper four pins can serve second timer channels.
// - First port latches keep their value through reset and are readable and writable per pin.
// - The timer select register bit of each channel decides if a shared pin is timer or GPIO.
// - A first-port direction bit of 1 enables the pin output buffer and 0 makes it an input.
// - Reset clears the first-port direction register so all its pins start as inputs.
// - First-port data reads give the latch for output pins and the pin level for input pins.
// - Data latch writes with the low byte strobe set update the latch and never change what an input pin reads.
// - The second port is eight bits wide with reset-independent readable and writable latches.
// - A second-port pin chosen by the converter channel select is forced to analog input.
// - Unselected second-port pins are plain digital I/O under the data and direction registers.
// - A second-port direction bit of 1 enables the output buffer and 0 leaves it high-Z input.
// - Reset clears the second-port direction register so all its pins start as inputs.
// - Second-port data reads give the latch for output pins and the pin level for input pins.
package dpio_pkg;

  // ***************************************************************
  // Register map
  // ***************************************************************
  localparam logic [15:0] FIRST_LATCH_IDX  = 16'h0440;
  localparam logic [15:0] SECOND_LATCH_IDX = 16'h0441;
  localparam logic [15:0] FIRST_DIR_IDX    = 16'h0442;
  localparam logic [15:0] SECOND_DIR_IDX   = 16'h0443;
  localparam logic [15:0] ADC_SEL_IDX      = 16'h0444;
  localparam logic [15:0] TIMER_SEL_IDX    = 16'h0445;

  // ***************************************************************
  // Fields and widths
  // ***************************************************************
  localparam int          PORT_W      = 8;
  localparam int          TCH_LO      = 4;
  localparam int          TCH_N       = 4;
  localparam int          ADC_SEL_W   = 5;
  localparam logic [4:0]  ADC_G_BASE  = 5'h10;
  localparam logic [7:0]  DIR_RESET   = 8'h00;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

  // Per-port pin bundle
  typedef struct packed {
    logic [PORT_W-1:0] o;
    logic [PORT_W-1:0] oe;
  } dpio_pins_t;

  // Timer channel request bundle for the four shared pins
  typedef struct packed {
    logic [TCH_N-1:0] out;
    logic [TCH_N-1:0] oe;
  } dpio_tch_t;

endpackage

// ---- hw/dpio_sync.sv ----
// Purpose: Two-flop synchroniser for a bus of pin levels
// Assumes: Single pclk domain, asynchronous active-low reset
// Notes:   First stage feeds only the second stage
module dpio_sync #(
  parameter int W = 8
) (
  input  wire logic         pclk,    // Bus clock
  input  wire logic         presetn, // Async reset, active low
  input  wire logic [W-1:0] d,       // Asynchronous input
  output logic      [W-1:0] q        // Synchronised output
);
  logic [W-1:0] meta_reg;

  // Two stages so metastability settles before any reader
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule

// ---- hw/dpio_top.sv ----
// Purpose: Two 8-bit parallel I/O ports behind an APB slave
// Assumes: pclk 125 MHz; timer and converter live outside this block
// Notes:   Pads are split into in/out/oe; the pad ring resolves the wire
module dpio_top
  import dpio_pkg::*;
(
  input  wire logic        pclk,           // Bus clock
  input  wire logic        presetn,        // Async reset, active low
  input  wire logic        psel,           // APB select
  input  wire logic        penable,        // APB access phase
  input  wire logic        pwrite,         // APB direction
  input  wire logic [15:0] paddr,          // APB byte address
  input  wire logic [31:0] pwdata,         // APB write data
  input  wire logic [3:0]  pstrb,          // APB byte strobes
  output logic      [31:0] prdata,         // APB read data
  output logic             pready,         // APB ready
  output logic             pslverr,        // APB error on unmapped address
  input  wire logic [7:0]  first_pin_in,   // First port pad levels
  output logic      [7:0]  first_pin_out,  // First port pad drive
  output logic      [7:0]  first_pin_oe,   // First port output enable
  input  wire logic [7:0]  second_pin_in,  // Second port pad levels
  output logic      [7:0]  second_pin_out, // Second port pad drive
  output logic      [7:0]  second_pin_oe,  // Second port output enable
  output logic      [7:0]  second_analog,  // Pin routed to converter
  input  wire logic [3:0]  tch_out,        // Timer channel drive level
  input  wire logic [3:0]  tch_oe,         // Timer channel drive enable
  output logic      [3:0]  tch_in          // Synchronised level to timer
);

  // ***************************************************************
  // Registers
  // ***************************************************************
  logic [7:0]           first_port_latch;   // No reset, holds through reset
  logic [7:0]           second_port_latch;
  logic [7:0]           first_port_direction;
  logic [7:0]           second_port_direction;
  logic                 adc_enable_reg;
  logic [ADC_SEL_W-1:0] adc_chan_reg;
  logic [TCH_N-1:0]     timer_sel_reg;
  logic [7:0]           first_sync;
  logic [7:0]           second_sync;
  logic [7:0]           adc_onehot;
  dpio_pins_t           first_next;
  dpio_pins_t           second_next;
  dpio_tch_t            tch;
  logic [15:0]          idx;
  logic                 aligned;
  logic                 hit;
  logic                 wr_en;
  logic                 rd_en;
  logic [31:0]          rd_next;

  assign tch.out = tch_out;
  assign tch.oe  = tch_oe;

  // Byte address to register index; only whole aligned words decode
  assign idx     = {2'b00, paddr[15:2]};
  assign aligned = (paddr[1:0] == 2'b00);
  assign hit = aligned && (idx == FIRST_LATCH_IDX || idx == SECOND_LATCH_IDX
                        || idx == FIRST_DIR_IDX || idx == SECOND_DIR_IDX
                        || idx == ADC_SEL_IDX || idx == TIMER_SEL_IDX);
  assign wr_en = psel && penable && pwrite && hit && pstrb[0];
  assign rd_en = psel && !penable && !pwrite;

  // ***************************************************************
  // Pin synchronisers
  // ***************************************************************
  dpio_sync #(.W(PORT_W)) u_sync_first (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (first_pin_in),
    .q       (first_sync)
  );

  dpio_sync #(.W(PORT_W)) u_sync_second (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (second_pin_in),
    .q       (second_sync)
  );

  // ***************************************************************
  // Data latches
  // ***************************************************************
  // Latches have no reset term so their contents survive reset
  always_ff @(posedge pclk) begin
    if (wr_en && idx == FIRST_LATCH_IDX) begin
      first_port_latch <= pwdata[7:0];
    end
    if (wr_en && idx == SECOND_LATCH_IDX) begin
      second_port_latch <= pwdata[7:0];
    end
  end

  // Direction and select registers clear on reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_port_direction  <= DIR_RESET;
      second_port_direction <= DIR_RESET;
      adc_enable_reg        <= 1'b0;
      adc_chan_reg          <= '0;
      timer_sel_reg         <= '0;
    end else if (wr_en) begin
      case (idx)
        FIRST_DIR_IDX:  first_port_direction  <= pwdata[7:0];
        SECOND_DIR_IDX: second_port_direction <= pwdata[7:0];
        ADC_SEL_IDX: begin
          adc_chan_reg   <= pwdata[ADC_SEL_W-1:0];
          adc_enable_reg <= pwdata[ADC_SEL_W];
        end
        TIMER_SEL_IDX:  timer_sel_reg <= pwdata[TCH_N-1:0];
        default: ;
      endcase
    end
  end

  // ***************************************************************
  // Pin drive
  // ***************************************************************
  // Converter select decodes to one pin of the second port
  always_comb begin
    adc_onehot = '0;
    for (int i = 0; i < PORT_W; i++) begin
      if (adc_enable_reg && adc_chan_reg == ADC_G_BASE + i[ADC_SEL_W-1:0]) begin
        adc_onehot[i] = 1'b1;
      end
    end
  end

  always_comb begin
    first_next.o  = first_port_latch;
    first_next.oe = first_port_direction;
    for (int i = 0; i < TCH_N; i++) begin
      if (timer_sel_reg[i]) begin
        first_next.o[TCH_LO+i]  = tch.out[i];
        first_next.oe[TCH_LO+i] = tch.oe[i];
      end
    end
    second_next.o  = second_port_latch & ~adc_onehot;
    second_next.oe = second_port_direction & ~adc_onehot;
  end

  // Registered pad outputs; one cycle after a register write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_pin_out  <= '0;
      first_pin_oe   <= '0;
      second_pin_out <= '0;
      second_pin_oe  <= '0;
      second_analog  <= '0;
      tch_in         <= '0;
    end else begin
      first_pin_out  <= first_next.o;
      first_pin_oe   <= first_next.oe;
      second_pin_out <= second_next.o;
      second_pin_oe  <= second_next.oe;
      second_analog  <= adc_onehot;
      tch_in         <= first_sync[TCH_LO +: TCH_N];
    end
  end

  // ***************************************************************
  // APB read path and response
  // ***************************************************************
  // Read data is captured in setup so it is stable in the access phase
  always_comb begin
    rd_next = RDATA_RESET;
    case (idx)
      FIRST_LATCH_IDX:
        rd_next[7:0] = (first_port_latch & first_port_direction)
                     | (first_sync & ~first_port_direction);
      SECOND_LATCH_IDX:
        rd_next[7:0] = (second_port_latch & second_port_direction)
                     | (second_sync & ~second_port_direction);
      FIRST_DIR_IDX:  rd_next[7:0] = first_port_direction;
      SECOND_DIR_IDX: rd_next[7:0] = second_port_direction;
      ADC_SEL_IDX:    rd_next[ADC_SEL_W:0] = {adc_enable_reg, adc_chan_reg};
      TIMER_SEL_IDX:  rd_next[TCH_N-1:0] = timer_sel_reg;
      default:        rd_next = RDATA_RESET;
    endcase
    if (!aligned) begin
      rd_next = RDATA_RESET;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= RDATA_RESET;
    end else if (rd_en) begin
      prdata <= rd_next;
    end
  end

  // Zero-wait answer: pready registered in setup, high in the access phase, so every access ends in two cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !hit;
    end
  end

  // ***************************************************************
  // Assertions
  // ***************************************************************
  a_dir_reset_input: assert property (
    @(posedge pclk) $rose(presetn) |-> (first_pin_oe == '0 && second_pin_oe == '0))
    else $error("Port pins not inputs after reset");

  a_first_dir_oe: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_en && idx == FIRST_DIR_IDX && timer_sel_reg == '0)
      |=> ##1 (first_pin_oe == $past(pwdata[7:0], 2)))
    else $error("First port enable does not follow direction write");

  a_second_dir_oe: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_en && idx == SECOND_DIR_IDX && adc_onehot == '0)
      |=> ##1 (second_pin_oe == $past(pwdata[7:0], 2)))
    else $error("Second port enable does not follow direction write");

  a_analog_override: assert property (
    @(posedge pclk) disable iff (!presetn)
    (second_analog != '0) |-> ((second_pin_oe & second_analog) == '0))
    else $error("Analog pin still driven");

  a_first_latch_read: assert property (
    @(posedge pclk) disable iff (!presetn)
    (rd_en && idx == FIRST_LATCH_IDX && first_port_direction == 8'hFF)
      |=> (prdata[7:0] == $past(first_port_latch)))
    else $error("First port read of output pins not the latch");

  a_second_pin_read: assert property (
    @(posedge pclk) disable iff (!presetn)
    (rd_en && idx == SECOND_LATCH_IDX && second_port_direction == 8'h00)
      |=> (prdata[7:0] == $past(second_pin_in, 3)))
    else $error("Second port read of input pins not the pin level");

  a_latch_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_en && idx == SECOND_LATCH_IDX) |=> (second_port_latch == $past(pwdata[7:0])))
    else $error("Second port latch missed a write");

  a_timer_drive: assert property (
    @(posedge pclk) disable iff (!presetn)
    (timer_sel_reg[0] && $stable(timer_sel_reg)) |=> (first_pin_out[TCH_LO] == $past(tch_out[0])))
    else $error("Timer channel not driving shared pin");

  a_apb_answer: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel && !penable) |=> (pready && pslverr == !$past(hit)))
    else $error("APB answer wrong");

endmodule

// ---- dv/dpio_board.sv ----
// Purpose: Board-side model of the pads on both ports
// Assumes: No pulls; the board drives every pin that the chip leaves alone
// Notes:   Converter-selected pins show the board level, as nothing on chip drives them
module dpio_board (
  input  wire logic [7:0] f_out, // First port drive from chip
  input  wire logic [7:0] f_oe,  // First port enable from chip
  input  wire logic [7:0] g_out, // Second port drive from chip
  input  wire logic [7:0] g_oe,  // Second port enable from chip
  input  wire logic [7:0] f_ext, // Board level, first port
  input  wire logic [7:0] g_ext, // Board level, second port
  output logic      [7:0] f_lvl, // Resolved first port wire
  output logic      [7:0] g_lvl  // Resolved second port wire
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************
  // Wire resolution
  // ****************************************************
  // Board takes every released pin, so no input ever floats to a guessed level
  assign f_lvl = (f_oe & f_out) | (~f_oe & f_ext);
  assign g_lvl = (g_oe & g_out) | (~g_oe & g_ext);
endmodule

// ---- dv/tb.sv ----
// Purpose: Self-checking bench for the dual parallel I/O ports
// Assumes: APB master with waits bounded; board model resolves the pads
// Notes:   Pin reads wait four cycles so the two-flop path has settled
module tb;
  import dpio_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic       g;
    logic [7:0] lat;
    logic [7:0] dir;
    logic [7:0] ext;
  } dpio_row_t;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb, tch_out, tch_oe, tch_in;
  logic [7:0]  f_in, f_out, f_oe, g_in, g_out, g_oe, g_ana, f_ext, g_ext, exp_v;
  int          num_errors, checked;
  dpio_row_t   rows [6];

  dpio_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .first_pin_in(f_in), .first_pin_out(f_out),
    .first_pin_oe(f_oe), .second_pin_in(g_in), .second_pin_out(g_out),
    .second_pin_oe(g_oe), .second_analog(g_ana), .tch_out(tch_out), .tch_oe(tch_oe),
    .tch_in(tch_in));
  dpio_board board (.f_out(f_out), .f_oe(f_oe), .g_out(g_out), .g_oe(g_oe),
    .f_ext(f_ext), .g_ext(g_ext), .f_lvl(f_in), .g_lvl(g_in));

  // 125 MHz bus clock
  always #4 pclk = ~pclk;

  // ****************************************************
  // Shared tasks
  // ****************************************************
  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One APB transfer; index is turned into a byte address, request held until pready
  task automatic apb(input logic w, input logic [15:0] idx, input logic [7:0] wd,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {idx[13:0], 2'b00};
    pwdata  <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      num_errors++;
      give_verdict();
    end
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic do_reset;
    presetn <= 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  // ****************************************************
  // Main sequence
  // ****************************************************
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 16'h0000;
    pwdata = 32'h0000_0000; pstrb = 4'hF; tch_out = 4'h0; tch_oe = 4'h0;
    f_ext = 8'h5A; g_ext = 8'hC3; num_errors = 0; checked = 0;
    rows = '{'{1'b0, 8'hA5, 8'hFF, 8'h00}, '{1'b0, 8'h3C, 8'h0F, 8'hC3},
             '{1'b0, 8'hFF, 8'h00, 8'h5A}, '{1'b1, 8'h96, 8'hFF, 8'h0F},
             '{1'b1, 8'h00, 8'hF0, 8'hFF}, '{1'b1, 8'h5A, 8'h00, 8'hA5}};
    do_reset();
    apb(1'b0, FIRST_DIR_IDX, 8'h00, rd, er);
    chk("first direction", rd, 32'h0);
    apb(1'b0, SECOND_DIR_IDX, 8'h00, rd, er);
    chk("second direction", rd, 32'h0);
    chk("enables after reset", {f_oe, g_oe}, 32'h0);
    // Latch loaded ahead of the direction bit so a new output never glitches
    foreach (rows[i]) begin
      apb(1'b1, FIRST_LATCH_IDX + 16'(rows[i].g), rows[i].lat, rd, er);
      apb(1'b1, FIRST_DIR_IDX + 16'(rows[i].g), rows[i].dir, rd, er);
      if (rows[i].g) g_ext <= rows[i].ext;
      else f_ext <= rows[i].ext;
      repeat (4) @(posedge pclk);
      exp_v = (rows[i].lat & rows[i].dir) | (rows[i].ext & ~rows[i].dir);
      apb(1'b0, FIRST_LATCH_IDX + 16'(rows[i].g), 8'h00, rd, er);
      chk("port read", rd, 32'(exp_v));
      chk("output enable", 32'(rows[i].g ? g_oe : f_oe), 32'(rows[i].dir));
      chk("pin drive", 32'(rows[i].g ? g_out : f_out), 32'(rows[i].lat));
    end
    // Every converter channel on the second port overrides its output buffer
    apb(1'b1, SECOND_DIR_IDX, 8'hFF, rd, er);
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, ADC_SEL_IDX, 8'h30 | 8'(i), rd, er);
      repeat (2) @(posedge pclk);
      exp_v = 8'h01 << i;
      chk("analog route", 32'(g_ana), 32'(exp_v));
      exp_v = ~exp_v;
      chk("analog enable", 32'(g_oe), 32'(exp_v));
    end
    apb(1'b1, ADC_SEL_IDX, 8'h00, rd, er);
    // Timer takes the upper first-port pins while the direction bits stay inputs
    apb(1'b1, FIRST_DIR_IDX, 8'h00, rd, er);
    tch_out <= 4'hA;
    tch_oe  <= 4'hF;
    apb(1'b1, TIMER_SEL_IDX, 8'h0F, rd, er);
    // Pad, two sync flops and the output flop: level reaches the timer four edges after the select write
    repeat (5) @(posedge pclk);
    chk("timer drive", 32'({f_out[7:4], f_oe[7:4]}), 32'h0000_00AF);
    chk("timer sample", 32'(tch_in), 32'h0000_000A);
    apb(1'b0, FIRST_LATCH_IDX, 8'h00, rd, er);
    chk("timer pin read", rd, {24'h000000, 4'hA, f_ext[3:0]});
    apb(1'b1, TIMER_SEL_IDX, 8'h00, rd, er);
    repeat (2) @(posedge pclk);
    chk("timer released", 32'(f_oe), 32'h0);
    // Unmapped index is refused and reads zero
    apb(1'b0, 16'h0446, 8'h00, rd, er);
    chk("unmapped error", {31'h0, er}, 32'h1);
    chk("unmapped data", rd, 32'h0);
    // Latches ride through a mid-run reset, directions do not
    apb(1'b1, FIRST_LATCH_IDX, 8'h69, rd, er);
    apb(1'b1, SECOND_LATCH_IDX, 8'h96, rd, er);
    do_reset();
    chk("enables after reset", {f_oe, g_oe}, 32'h0);
    apb(1'b1, FIRST_DIR_IDX, 8'hFF, rd, er);
    apb(1'b1, SECOND_DIR_IDX, 8'hFF, rd, er);
    apb(1'b0, FIRST_LATCH_IDX, 8'h00, rd, er);
    chk("first latch kept", rd, 32'h69);
    apb(1'b0, SECOND_LATCH_IDX, 8'h00, rd, er);
    chk("second latch kept", rd, 32'h96);
    // A write with the low byte strobe off must leave the latch alone
    pstrb <= 4'hE;
    apb(1'b1, FIRST_LATCH_IDX, 8'h00, rd, er);
    pstrb <= 4'hF;
    apb(1'b0, FIRST_LATCH_IDX, 8'h00, rd, er);
    chk("strobe ignored", rd, 32'h69);
    give_verdict();
  end
endmodule
